// file: bench/failover_chk.sv
// port-level checks for the network command failover block
`timescale 1ns/1ps
`default_nettype none
module failover_chk
  import failover_pkg::*;
(
  input wire logic                  mclk_in,
  input wire logic                  rst_in,
  input wire logic                  source_network_in,
  input wire logic                  group_raise_lower_select_in,
  input wire logic                  save_in,
  input wire logic                  power_up_in,
  input wire logic                  service_request_in,
  input wire logic [NUM_GROUPS-1:0] group_network_out,
  input wire logic                  net_failed_out,
  input wire logic                  net_loop_out,
  input wire logic                  hw_loop_out,
  input wire failover_pkg::monitor_e command_source_monitor_out,
  input wire logic [4:0]            node_addr_out,
  input wire logic [6:0]            drop_steps_active_out,
  input wire logic                  service_id_send_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_excl; !(net_loop_out && hw_loop_out); endproperty
  a_excl: assert property (p_excl) else $error("both loop flags set");
  property p_svc; service_id_send_out == $past(service_request_in); endproperty
  a_svc: assert property (p_svc) else $error("id send not tracking request");
  property p_src; !source_network_in |-> ##[1:2] group_network_out == '0; endproperty
  a_src: assert property (p_src) else $error("group left on network");
  property p_grp;
    !group_raise_lower_select_in |-> ##[1:2] !group_network_out[GRP_RAISE_LOWER];
  endproperty
  a_grp: assert property (p_grp) else $error("raise lower not forced");
  property p_ps; net_failed_out |-> ##[0:1] !group_network_out[GRP_PROC_SETPT]; endproperty
  a_ps: assert property (p_ps) else $error("setpoint group on failed net");
  property p_mon;
    $rose(net_failed_out) && source_network_in |-> ##[0:2] command_source_monitor_out == MON_FAULT;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor missed fault");
  property p_addr; $changed(node_addr_out) |-> $past(save_in) || $past(save_in, 2); endproperty
  a_addr: assert property (p_addr) else $error("address moved without save");
  property p_drop;
    $changed(drop_steps_active_out) |-> $past(power_up_in) || $past(power_up_in, 2);
  endproperty
  a_drop: assert property (p_drop) else $error("interval moved without power up");
  c_recover: cover property ($fell(net_failed_out));
  c_net_loop: cover property ($rose(net_loop_out));
  c_hw_loop: cover property ($rose(hw_loop_out));
endmodule // failover_chk
bind network_command_failover failover_chk u_chk (.mclk_in, .rst_in, .source_network_in,
  .group_raise_lower_select_in, .save_in, .power_up_in, .service_request_in,
  .group_network_out, .net_failed_out, .net_loop_out, .hw_loop_out,
  .command_source_monitor_out, .node_addr_out, .drop_steps_active_out, .service_id_send_out);
`default_nettype wire

// file: bench/network_command_failover_test.sv
// self-checking bench for the network command failover block
`timescale 1ns/1ps
`default_nettype none
module network_command_failover_test;
  import failover_pkg::*;
  localparam int SC = 10;  // short step keeps windows at tens of cycles
  logic mclk_in = 0, rst_in = 1, net_msg_valid_in, send = 0, revert_lock_in = 0;
  logic source_network_in = 1, group_dispatch_select_in = 1, group_breaker_aux_select_in = 1;
  logic group_raise_lower_select_in = 1, group_process_setpoint_select_in = 1;
  logic power_up_in = 0, switches_open_in = 0, save_in = 0, addr_tool_assigned_in = 0;
  logic service_request_in = 0, net_failed_out, net_loop_out, hw_loop_out, service_id_send_out;
  logic [7:0] net_discrete_in, net_analog_in, hw_discrete_in = 8'h3c, hw_analog_in = 8'h77;
  logic [7:0] peer_cmd = 8'ha5, config_key_in = 8'h00, cmd_discrete_out, cmd_analog_out;
  logic [6:0] drop_steps_in = 7'h04, drop_steps_active_out;
  logic [4:0] addr_entry_in = 5'h05, node_addr_out;
  logic [3:0] group_network_out;
  monitor_e command_source_monitor_out;
  int failures = 0, cmp_count = 0, n;
  network_command_failover #(.STEP_CYCLES_P(SC)) DUT (.mclk_in, .rst_in, .net_msg_valid_in,
    .net_discrete_in, .net_analog_in, .hw_discrete_in, .hw_analog_in, .source_network_in,
    .revert_lock_in, .group_dispatch_select_in, .group_breaker_aux_select_in,
    .group_raise_lower_select_in, .group_process_setpoint_select_in, .power_up_in,
    .config_key_in, .switches_open_in, .save_in, .drop_steps_in, .addr_entry_in,
    .addr_tool_assigned_in, .service_request_in, .cmd_discrete_out, .cmd_analog_out,
    .group_network_out, .net_failed_out, .net_loop_out, .hw_loop_out,
    .command_source_monitor_out, .node_addr_out, .drop_steps_active_out, .service_id_send_out);
  peer_node PEER (.clk_in(mclk_in), .send_in(send), .cmd_in(peer_cmd),
    .valid_out(net_msg_valid_in), .data_out(net_discrete_in), .ana_out(net_analog_in));
  initial forever #50 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  task automatic s(input int k);
    w(k);
    @(negedge mclk_in);
  endtask
  task automatic wf(input logic v);
    n = 0;
    while (net_failed_out !== v && n < 300) begin
      @(negedge mclk_in);
      n++;
    end
    chk(n < 300, 1'b1);
  endtask
  task automatic cfg(input logic [7:0] k, input logic sw, tl, input logic [4:0] a, ex);
    w(1);
    config_key_in <= k;
    switches_open_in <= sw;
    addr_tool_assigned_in <= tl;
    addr_entry_in <= a;
    save_in <= 1;
    w(1);
    save_in <= 0;
    s(3);
    chk(node_addr_out, ex);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    w(3000);
    failures++;
    final_report;
  end
  initial begin
    s(5);
    chk(net_failed_out, 1'b1);
    chk(command_source_monitor_out, MON_HARDWARE);
    chk(node_addr_out, 5'h10);
    chk(drop_steps_active_out, 7'h02);
    w(1);
    rst_in <= 0;
    send <= 1;
    wf(0);
    chk(n >= 50, 1'b1);
    s(2);
    chk(group_network_out, 4'hf);
    chk(command_source_monitor_out, MON_NETWORK);
    chk(cmd_discrete_out, 8'ha5);
    chk(cmd_analog_out, 8'h5a);
    w(1);
    group_raise_lower_select_in <= 0;
    s(2);
    chk(group_network_out, 4'hb);
    w(1);
    group_raise_lower_select_in <= 1;
    send <= 0;
    wf(1);
    chk(n <= 45, 1'b1);
    s(2);
    chk(cmd_discrete_out, 8'h3c);
    chk(cmd_analog_out, 8'h77);
    chk(group_network_out, 4'h0);
    chk(command_source_monitor_out, MON_FAULT);
    $display("test hardware revert done");
    w(1);
    peer_cmd <= 8'h5a;
    send <= 1;
    wf(0);
    w(1);
    revert_lock_in <= 1;
    send <= 0;
    wf(1);
    s(2);
    chk(net_loop_out, 1'b1);
    chk(cmd_discrete_out, 8'h5a);
    chk(cmd_analog_out, 8'ha5);
    w(1);
    hw_discrete_in <= 8'h5a;
    s(3);
    chk(hw_loop_out, 1'b1);
    chk(net_loop_out, 1'b0);
    w(1);
    hw_discrete_in <= 8'h5b;
    send <= 1;
    wf(0);
    s(2);
    chk(cmd_discrete_out, 8'h5b);
    chk(hw_loop_out, 1'b1);
    w(1);
    peer_cmd <= 8'h5b;
    s(8);
    chk(hw_loop_out, 1'b0);
    chk(command_source_monitor_out, MON_NETWORK);
    w(1);
    hw_discrete_in <= 8'h3c;
    send <= 0;
    wf(1);
    w(1);
    peer_cmd <= 8'h11;
    send <= 1;
    wf(0);
    s(2);
    chk(net_loop_out, 1'b1);
    chk(group_network_out, 4'hc);
    chk(cmd_discrete_out, 8'h5b);
    w(1);
    peer_cmd <= 8'h5b;
    s(8);
    chk(net_loop_out, 1'b0);
    $display("test lock in last done");
    w(1);
    source_network_in <= 0;
    s(2);
    chk(group_network_out, 4'h0);
    chk(cmd_discrete_out, 8'h3c);
    w(1);
    source_network_in <= 1;
    service_request_in <= 1;
    s(2);
    chk(service_id_send_out, 1'b1);
    cfg(8'h30, 1'b1, 1'b0, 5'h05, 5'h10);
    cfg(8'h31, 1'b0, 1'b0, 5'h05, 5'h10);
    cfg(8'h31, 1'b1, 1'b0, 5'h05, 5'h05);
    cfg(8'h31, 1'b1, 1'b1, 5'h09, 5'h05);
    chk(drop_steps_active_out, 7'h02);
    w(1);
    power_up_in <= 1;
    w(1);
    power_up_in <= 0;
    s(2);
    chk(drop_steps_active_out, 7'h04);
    w(1);
    drop_steps_in <= 7'h65;
    cfg(8'h31, 1'b1, 1'b0, 5'h00, 5'h05);
    chk(node_addr_out != 5'(PEER.NODE_ADDR), 1'b1);
    w(1);
    power_up_in <= 1;
    w(1);
    power_up_in <= 0;
    s(2);
    chk(drop_steps_active_out, 7'h04);
    $display("test configuration done");
    final_report;
  end
endmodule // network_command_failover_test
`default_nettype wire

// file: bench/peer_node.sv
// peer node model: sends command messages at a fixed spacing
`timescale 1ns/1ps
`default_nettype none
module peer_node #(
  parameter int GAP = 4  // five messages per short window, well above three
) (
  input  wire logic       clk_in,
  input  wire logic       send_in,
  input  wire logic [7:0] cmd_in,
  output var logic        valid_out,
  output var logic  [7:0] data_out,
  output var logic  [7:0] ana_out
);
  localparam int NODE_ADDR = 3;
  int cnt = 0;
  initial {valid_out, data_out, ana_out} = '0;
  always @(posedge clk_in) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    valid_out <= send_in && cnt == 0;
    // between messages the words toggle so a stale value never looks valid
    data_out <= (send_in && cnt == 0) ? cmd_in : ~data_out;
    ana_out <= (send_in && cnt == 0) ? ~cmd_in : ~ana_out;
  end
endmodule // peer_node
`default_nettype wire

// file: src/failover_pkg.sv
// constants for the network command failover block
package failover_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned STEP_MS         = 500;
  localparam int unsigned STEP_CYCLES     = (CLK_HZ / 1000) * STEP_MS;
  localparam int unsigned DROP_STEPS_MIN  = 1;
  localparam int unsigned DROP_STEPS_MAX  = 100;
  localparam int unsigned MSG_THRESHOLD   = 3;
  localparam int unsigned RECOVER_MULT    = 3;
  localparam int unsigned CONFIG_KEY      = 49;
  localparam int unsigned ADDR_MIN        = 1;
  localparam int unsigned ADDR_MAX        = 16;
  localparam logic [4:0]  ADDR_RESET      = 5'h10;
  localparam logic [6:0]  DROP_RESET      = 7'h02;
  localparam int unsigned NUM_GROUPS      = 4;
  localparam int unsigned GRP_DISPATCH    = 0;
  localparam int unsigned GRP_BREAKER_AUX = 1;
  localparam int unsigned GRP_RAISE_LOWER = 2;
  localparam int unsigned GRP_PROC_SETPT  = 3;
  typedef enum logic [1:0] {MON_HARDWARE, MON_NETWORK, MON_FAULT} monitor_e;
endpackage

// file: src/network_command_failover.sv
// network command failover: source selection, dropout detection, revert policies
//
// Contract
// - dropout interval 0.5 s to 50 s, 0.5 s steps
// - fewer than three messages per interval: failed
// - recovery needs three messages in 3x interval
// - hardware policy: switch to hardware at failure
// - hardware policy: back to network at recovery
// - lock-in-last latches last command at failure
// - network loop returns on matching network command
// - hardware loop: matching hardware inputs take over
// - hardware loop returns when network matches hardware
// - source selector hardware forces every input
// - per-group selector, true network, false hardware
// - setpoint and raise/lower groups always revert
// - config changes need key 49, switches open
// - address 1 to 16, applied on save
// - tool-assigned address keeps previous on save
// - service request sends the unique code
// - saved dropout interval applies after power-up
// - loop flags exclusive, set on lock-in failure
// - monitor shows hardware, network or fault
`timescale 1ns/1ps
`default_nettype none
module network_command_failover
#(
  parameter int unsigned DW            = 8,
  parameter int unsigned STEP_CYCLES_P = failover_pkg::STEP_CYCLES
) (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  input  wire logic                  net_msg_valid_in,
  input  wire logic [DW-1:0]         net_discrete_in,
  input  wire logic [DW-1:0]         net_analog_in,
  input  wire logic [DW-1:0]         hw_discrete_in,
  input  wire logic [DW-1:0]         hw_analog_in,
  input  wire logic                  source_network_in,
  input  wire logic                  revert_lock_in,
  input  wire logic                  group_dispatch_select_in,
  input  wire logic                  group_breaker_aux_select_in,
  input  wire logic                  group_raise_lower_select_in,
  input  wire logic                  group_process_setpoint_select_in,
  input  wire logic                  power_up_in,
  input  wire logic [7:0]            config_key_in,
  input  wire logic                  switches_open_in,
  input  wire logic                  save_in,
  input  wire logic [6:0]            drop_steps_in,
  input  wire logic [4:0]            addr_entry_in,
  input  wire logic                  addr_tool_assigned_in,
  input  wire logic                  service_request_in,
  output logic [DW-1:0]              cmd_discrete_out,
  output logic [DW-1:0]              cmd_analog_out,
  output logic [failover_pkg::NUM_GROUPS-1:0] group_network_out,
  output logic                       net_failed_out,
  output logic                       net_loop_out,
  output logic                       hw_loop_out,
  output var failover_pkg::monitor_e command_source_monitor_out,
  output logic [4:0]                 node_addr_out,
  output logic [6:0]                 drop_steps_active_out,
  output logic                       service_id_send_out
);
  import failover_pkg::*;

  typedef enum {ST_NETWORK, ST_HW_REVERT, ST_LOCKED, ST_HW_LOOP} mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  // inclusive bound test, shared by the interval and address checks
  function automatic logic in_range(input logic [6:0] val, input logic [6:0] lo,
                                    input logic [6:0] hi);
    return (val >= lo) && (val <= hi);
  endfunction

  // a group rides the network only while every term agrees
  function automatic logic route_net(input logic global_sel, input logic own_sel,
                                     input logic healthy);
    return global_sel && own_sel && healthy;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage
  logic [6:0]  drop_saved_ff;
  logic [6:0]  drop_active_ff;
  logic [4:0]  addr_ff;
  logic        cfg_ok;
  logic        drop_legal;
  logic        addr_legal;
  logic        drop_load;
  logic        addr_load;
  assign cfg_ok     = (config_key_in == 8'(CONFIG_KEY)) && switches_open_in;
  assign drop_legal = in_range(drop_steps_in, 7'(DROP_STEPS_MIN), 7'(DROP_STEPS_MAX));
  assign addr_legal = in_range({2'h0, addr_entry_in}, 7'(ADDR_MIN), 7'(ADDR_MAX));
  assign drop_load  = save_in && cfg_ok && drop_legal;
  // a tool-assigned address simply stays as it was, so a save cannot move it
  assign addr_load  = save_in && cfg_ok && addr_legal && !addr_tool_assigned_in;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      drop_saved_ff <= DROP_RESET;
    end else if (drop_load) begin
      drop_saved_ff <= drop_steps_in;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_ff <= ADDR_RESET;
    end else if (addr_load) begin
      addr_ff <= addr_entry_in;
    end
  end

  // the live interval is taken from storage only on power-up
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) drop_active_ff <= DROP_RESET;
    else if (power_up_in) drop_active_ff <= drop_saved_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // window timing
  logic [31:0] tick_cnt_ff;
  logic [8:0]  step_cnt_ff;
  logic [1:0]  msg_cnt_ff;
  logic        step_tick;
  logic [8:0]  win_steps;
  logic        win_end;
  logic        enough;
  logic        net_failed_ff;
  logic        msg_count;

  assign step_tick = (tick_cnt_ff == STEP_CYCLES_P - 1);
  // failed networks look over three intervals, healthy ones over one
  assign win_steps = net_failed_ff ? 9'(drop_active_ff * RECOVER_MULT)
                                   : 9'(drop_active_ff);
  assign win_end   = step_tick && (step_cnt_ff >= win_steps - 9'h001);
  assign enough    = (msg_cnt_ff == 2'(MSG_THRESHOLD)) ||
                     ((msg_cnt_ff == 2'(MSG_THRESHOLD - 1)) && net_msg_valid_in);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) tick_cnt_ff <= '0;
    else tick_cnt_ff <= step_tick ? '0 : tick_cnt_ff + 32'h1;
  end

  // saturating at the threshold keeps the two-bit counter from wrapping
  assign msg_count = net_msg_valid_in && (msg_cnt_ff != 2'(MSG_THRESHOLD));

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      step_cnt_ff <= '0;
    end else if (win_end) begin
      step_cnt_ff <= '0;
    end else if (step_tick) begin
      step_cnt_ff <= step_cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      msg_cnt_ff <= '0;
    end else if (win_end) begin
      msg_cnt_ff <= '0;
    end else if (msg_count) begin
      msg_cnt_ff <= msg_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) net_failed_ff <= 1'b1;
    else if (win_end) net_failed_ff <= !enough;
  end

  ////////////////////////////////////////////////////////////////////////////
  // revert policy state
  mode_e       mode_ff;
  mode_e       nxt_mode;
  logic [DW-1:0] held_disc_ff;
  logic [DW-1:0] held_ana_ff;
  logic [DW-1:0] last_disc_ff;
  logic [DW-1:0] last_ana_ff;
  logic        fail_now;
  logic        net_ok;
  logic        lock_now;
  logic [DW-1:0] lock_disc;
  logic [DW-1:0] lock_ana;

  assign fail_now = win_end && !net_failed_ff && !enough;
  assign net_ok   = !net_failed_ff;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      last_disc_ff <= '0;
      last_ana_ff  <= '0;
    end else if (net_msg_valid_in) begin
      last_disc_ff <= net_discrete_in;
      last_ana_ff  <= net_analog_in;
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      ST_NETWORK: begin
        if (fail_now) nxt_mode = revert_lock_in ? ST_LOCKED : ST_HW_REVERT;
      end
      ST_HW_REVERT: begin
        if (net_ok) nxt_mode = ST_NETWORK;
      end
      ST_LOCKED: begin
        if (net_ok && net_msg_valid_in && net_discrete_in == held_disc_ff)
          nxt_mode = ST_NETWORK;
        else if (hw_discrete_in == held_disc_ff) nxt_mode = ST_HW_LOOP;
      end
      ST_HW_LOOP: begin
        if (net_ok && net_msg_valid_in && net_discrete_in == hw_discrete_in)
          nxt_mode = ST_NETWORK;
      end
      default: nxt_mode = ST_HW_REVERT;
    endcase
  end

  // a message landing on the failing edge is the newest command, so it wins the latch
  assign lock_now  = (mode_ff == ST_NETWORK) && (nxt_mode == ST_LOCKED);
  assign lock_disc = net_msg_valid_in ? net_discrete_in : last_disc_ff;
  assign lock_ana  = net_msg_valid_in ? net_analog_in : last_ana_ff;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff <= ST_HW_REVERT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      held_disc_ff <= '0;
      held_ana_ff  <= '0;
    end else if (lock_now) begin
      held_disc_ff <= lock_disc;
      held_ana_ff  <= lock_ana;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection per group
  logic [NUM_GROUPS-1:0] grp_sel;
  logic [NUM_GROUPS-1:0] grp_net;
  logic                  main_net;
  logic                  policy_net;
  logic [DW-1:0]         main_disc;
  logic [DW-1:0]         main_ana;
  logic                  use_held;

  assign grp_sel = {group_process_setpoint_select_in, group_raise_lower_select_in,
                    group_breaker_aux_select_in, group_dispatch_select_in};
  assign policy_net = (mode_ff == ST_NETWORK);
  assign grp_net[GRP_DISPATCH]    = route_net(source_network_in, grp_sel[GRP_DISPATCH],
                                              policy_net);
  assign grp_net[GRP_BREAKER_AUX] = route_net(source_network_in, grp_sel[GRP_BREAKER_AUX],
                                              policy_net);
  // these two follow network health only, never the lock
  assign grp_net[GRP_RAISE_LOWER] = route_net(source_network_in, grp_sel[GRP_RAISE_LOWER],
                                              net_ok);
  assign grp_net[GRP_PROC_SETPT]  = route_net(source_network_in, grp_sel[GRP_PROC_SETPT],
                                              net_ok);
  assign main_net  = grp_net[GRP_DISPATCH];
  // the held word shows only while the dispatch path still asks for the network
  assign use_held  = source_network_in && grp_sel[GRP_DISPATCH]
                     && (mode_ff == ST_LOCKED);
  assign main_disc = main_net ? last_disc_ff : use_held ? held_disc_ff : hw_discrete_in;
  assign main_ana  = main_net ? last_ana_ff : use_held ? held_ana_ff : hw_analog_in;

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  monitor_e nxt_monitor;
  assign nxt_monitor = main_net ? MON_NETWORK
                     : (net_failed_ff && source_network_in) ? MON_FAULT
                     : MON_HARDWARE;

  // every output is its own short register, one cycle behind the state it shows
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_discrete_out <= '0;
      cmd_analog_out   <= '0;
    end else begin
      cmd_discrete_out <= main_disc;
      cmd_analog_out   <= main_ana;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      group_network_out <= '0;
    end else begin
      group_network_out <= grp_net;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      net_failed_out <= 1'b1;
    end else begin
      net_failed_out <= net_failed_ff;
    end
  end

  // both flags come from one state, so they can never be high together
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      net_loop_out <= 1'b0;
      hw_loop_out  <= 1'b0;
    end else begin
      net_loop_out <= (mode_ff == ST_LOCKED);
      hw_loop_out  <= (mode_ff == ST_HW_LOOP);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      command_source_monitor_out <= MON_HARDWARE;
    end else begin
      command_source_monitor_out <= nxt_monitor;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      node_addr_out <= ADDR_RESET;
    end else begin
      node_addr_out <= addr_ff;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      drop_steps_active_out <= DROP_RESET;
    end else begin
      drop_steps_active_out <= drop_active_ff;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      service_id_send_out <= 1'b0;
    end else begin
      service_id_send_out <= service_request_in;
    end
  end
endmodule // network_command_failover
`default_nettype wire
